// ---- inc/iofs_pkg.sv ----
// constants and types for the function and sense strobe block
package iofs_pkg;
    localparam int unsigned CLK_HZ      = 125_000_000;
    localparam int unsigned STROBE_NS   = 6000;
    localparam int unsigned CLK_NS      = 1_000_000_000 / CLK_HZ;
    // least time, rounded up
    localparam int unsigned STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CODE_W      = 12;
    localparam int unsigned CNT_W       = 10;
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STROBE_CYC - 1);

    // request kinds, as on the command port
    typedef enum logic [1:0] {
        IOFS_IN_FUNC  = 2'h0,
        IOFS_IN_SENSE = 2'h1,
        IOFS_OUT_FUNC = 2'h2,
        IOFS_OUT_SENSE = 2'h3
    } iofs_kind_e;

    typedef enum logic [2:0] {
        IOFS_IDLE   = 3'h1,
        IOFS_STROBE = 3'h2,
        IOFS_DONE   = 3'h4
    } iofs_state_e;
endpackage : iofs_pkg

// ---- inc/iofs_tmr_if.sv ----
// interface between sequencer and strobe timer
interface iofs_tmr_if;
    import iofs_pkg::*;
    logic start;
    logic last;
    modport ctl (output start, input last);
    modport tmr (input start, output last);
endinterface : iofs_tmr_if

// ---- logic/iofs_timer.sv ----
// strobe length counter
module iofs_timer
    import iofs_pkg::*;
(
    input  wire logic  clk_in,
    input  wire logic  rst_in,
    iofs_tmr_if.tmr    tif
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             run_reg;
    logic             run_next;

    // next count: run from start until last cycle of strobe
    always_comb begin
        cnt_next = cnt_reg;
        run_next = run_reg;
        if (tif.start) begin
            cnt_next = CNT_ZERO;
            run_next = 1'b1;
        end else if (run_reg) begin
            if (cnt_reg == CNT_LAST) begin
                run_next = 1'b0;
            end else begin
                cnt_next = cnt_reg + CNT_W'(1);
            end
        end
    end

    // registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_reg <= CNT_ZERO;
            run_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            run_reg <= run_next;
        end
    end

    assign tif.last = run_reg && (cnt_reg == CNT_LAST);
endmodule : iofs_timer

// ---- logic/iofs_top.sv ----
// computer-side function and sense strobe sequencer
module iofs_top
    import iofs_pkg::*;
#(
    parameter bit TRANSFER_GROUP = 1'b0
) (
    input  wire logic              CLK_IN,
    input  wire logic              RST_IN,
    input  wire logic              REQ_VALID_IN,
    input  wire logic [1:0]        REQ_KIND_IN,
    input  wire logic [CODE_W-1:0] REQ_CODE_IN,
    output logic                   REQ_READY_OUT,
    input  wire logic              SENSE_RESP_IN,
    output logic [CODE_W-1:0]      FUNC_CODE_OUT,
    output logic                   IN_FUNC_RDY_OUT,
    output logic                   IN_SENSE_RDY_OUT,
    output logic                   OUT_FUNC_RDY_OUT,
    output logic                   OUT_SENSE_RDY_OUT,
    output logic                   DONE_OUT,
    output logic                   RESULT_OUT,
    output logic                   REJECT_OUT
);
    iofs_tmr_if tif ();

    iofs_state_e       state_reg;
    iofs_state_e       state_next;
    logic [CODE_W-1:0] code_reg;
    logic [CODE_W-1:0] code_next;
    logic [3:0]        strb_reg;
    logic [3:0]        strb_next;
    logic              done_reg;
    logic              done_next;
    logic              res_reg;
    logic              res_next;
    logic              rej_reg;
    logic              rej_next;
    logic              kind_ok;

    // one-hot strobe pattern for a request kind
    function automatic logic [3:0] kind_onehot(input logic [1:0] k);
        logic [3:0] v;
        v = 4'h0;
        v[k] = 1'b1;
        return v;
    endfunction : kind_onehot

    // input kinds are absent on the transfer group
    function automatic logic kind_allowed(input logic [1:0] k);
        return !(TRANSFER_GROUP && (k == IOFS_IN_FUNC || k == IOFS_IN_SENSE));
    endfunction : kind_allowed

    // true while a sense strobe of either direction is up
    function automatic logic is_sense(input logic [3:0] s);
        return s[IOFS_IN_SENSE] || s[IOFS_OUT_SENSE];
    endfunction : is_sense

    iofs_timer u_timer (
        .clk_in (CLK_IN),
        .rst_in (RST_IN),
        .tif    (tif)
    );

    ////////////////////////////////////////////////////////////////////
    // sequencer next state
    always_comb begin
        state_next = state_reg;
        code_next  = code_reg;
        strb_next  = strb_reg;
        done_next  = 1'b0;
        res_next   = res_reg;
        rej_next   = 1'b0;
        tif.start  = 1'b0;
        kind_ok    = kind_allowed(REQ_KIND_IN);
        case (state_reg)
            IOFS_IDLE: begin
                if (REQ_VALID_IN && !kind_ok) begin
                    rej_next = 1'b1;
                end else if (REQ_VALID_IN) begin
                    code_next  = REQ_CODE_IN;
                    strb_next  = kind_onehot(REQ_KIND_IN);
                    tif.start  = 1'b1;
                    state_next = IOFS_STROBE;
                end
            end
            IOFS_STROBE: begin
                if (tif.last) begin
                    strb_next = 4'h0;
                    // sample at strobe end, invert on low code bit
                    if (is_sense(strb_reg)) begin
                        res_next = SENSE_RESP_IN ^ code_reg[0];
                    end
                    done_next  = 1'b1;
                    state_next = IOFS_DONE;
                end
            end
            IOFS_DONE: begin
                state_next = IOFS_IDLE;
            end
            default: begin
                state_next = IOFS_IDLE;
                strb_next  = 4'h0;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            state_reg <= IOFS_IDLE;
            code_reg  <= 12'h000;
            strb_reg  <= 4'h0;
            done_reg  <= 1'b0;
            res_reg   <= 1'b0;
            rej_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            code_reg  <= code_next;
            strb_reg  <= strb_next;
            done_reg  <= done_next;
            res_reg   <= res_next;
            rej_reg   <= rej_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign REQ_READY_OUT     = (state_reg == IOFS_IDLE);
    assign FUNC_CODE_OUT     = code_reg;
    assign IN_FUNC_RDY_OUT   = strb_reg[IOFS_IN_FUNC];
    assign IN_SENSE_RDY_OUT  = strb_reg[IOFS_IN_SENSE];
    assign OUT_FUNC_RDY_OUT  = strb_reg[IOFS_OUT_FUNC];
    assign OUT_SENSE_RDY_OUT = strb_reg[IOFS_OUT_SENSE];
    assign DONE_OUT          = done_reg;
    assign RESULT_OUT        = res_reg;
    assign REJECT_OUT        = rej_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    logic [CNT_W:0] hi_cnt_reg;
    logic [CNT_W:0] hi_cnt_next;

    // high cycles of the current strobe so far, cleared while all are low
    always_comb begin
        hi_cnt_next = hi_cnt_reg + (CNT_W+1)'(1);
        if (strb_reg == 4'h0) begin
            hi_cnt_next = '0;
        end
    end

    // length counter register
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            hi_cnt_reg <= '0;
        end else begin
            hi_cnt_reg <= hi_cnt_next;
        end
    end

    // strobe shape; a reset in mid strobe also drops it, so skip that edge
    strobe_length_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (!$past(RST_IN) && $fell(|strb_reg)) |->
        ($past(hi_cnt_reg) == (CNT_W+1)'(STROBE_CYC - 1)))
        else $error("strobe length wrong");

    strobe_bound_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (|strb_reg) |-> (hi_cnt_reg < (CNT_W+1)'(STROBE_CYC)))
        else $error("strobe too long");

    timer_sync_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        tif.last |-> (hi_cnt_reg == (CNT_W+1)'(STROBE_CYC - 1)))
        else $error("timer end out of step");

    done_pulse_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (!$past(RST_IN) && $fell(|strb_reg)) |-> DONE_OUT ##1 !DONE_OUT)
        else $error("done not with strobe end");

    done_at_end_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        DONE_OUT |-> $fell(|strb_reg))
        else $error("done without strobe end");

    // one strobe at a time, code steady under it
    one_strobe_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        $onehot0(strb_reg))
        else $error("more than one strobe");

    code_stable_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (|strb_reg && $past(|strb_reg)) |-> $stable(FUNC_CODE_OUT))
        else $error("code moved during strobe");

    code_present_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        $rose(|strb_reg) |-> (FUNC_CODE_OUT == $past(REQ_CODE_IN)))
        else $error("code not on lines with strobe");

    code_hold_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (!$past(RST_IN) && !$rose(|strb_reg)) |-> $stable(FUNC_CODE_OUT))
        else $error("code moved outside request");

    // sense sampling at the strobe end only
    sense_sample_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (!$past(RST_IN) && ($fell(IN_SENSE_RDY_OUT) || $fell(OUT_SENSE_RDY_OUT))) |->
        (RESULT_OUT == ($past(SENSE_RESP_IN) ^ FUNC_CODE_OUT[0])))
        else $error("sense result wrong");

    result_hold_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (!$past(RST_IN) && !$fell(IN_SENSE_RDY_OUT) && !$fell(OUT_SENSE_RDY_OUT)) |->
        $stable(RESULT_OUT))
        else $error("result changed early");

    // request handshake and refusals
    no_input_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        TRANSFER_GROUP |-> !(IN_FUNC_RDY_OUT || IN_SENSE_RDY_OUT))
        else $error("input strobe on transfer group");

    reject_pulse_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (REQ_VALID_IN && REQ_READY_OUT && !kind_allowed(REQ_KIND_IN)) |=>
        (REJECT_OUT && (strb_reg == 4'h0)))
        else $error("refused kind not rejected");

    reject_quiet_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        REJECT_OUT |-> ($past(REQ_VALID_IN) && !kind_allowed($past(REQ_KIND_IN))))
        else $error("reject without refused kind");

    ready_busy_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (|strb_reg || DONE_OUT) |-> !REQ_READY_OUT)
        else $error("ready while busy");

    start_strobe_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (REQ_VALID_IN && REQ_READY_OUT && kind_allowed(REQ_KIND_IN)) |=>
        (strb_reg == kind_onehot($past(REQ_KIND_IN))))
        else $error("strobe not raised");
endmodule : iofs_top

// ---- test/iofs_equip.sv ----
// external equipment model on the cable group
module iofs_equip
    import iofs_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic [CODE_W-1:0] func_code_in,
    input  wire logic [3:0]        strobe_in,
    input  wire logic [10:0]       salt_in,
    output logic                   sense_resp_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic toggle_reg = 1'b0;
    logic present;
    // no condition is named outside a sense strobe, so the line churns
    always @(posedge clk_in) toggle_reg <= ~toggle_reg;
    // condition chosen by the upper code bits, put on the line only under a sense strobe
    assign present = ^(func_code_in[11:1] ^ salt_in);
    assign sense_resp_out = (strobe_in[1] | strobe_in[3]) ? present : toggle_reg;
endmodule : iofs_equip

// ---- test/tb_io_function_sense_signalling.sv ----
// self-checking bench for the function and sense strobe block
module tb_io_function_sense_signalling
    import iofs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk, rst, valid, ready, resp, done, result, reject;
    logic [1:0]        kind;
    logic [CODE_W-1:0] code, code_out;
    wire  [3:0]        stb, x_stb;
    logic [10:0]       salt;
    logic              x_reject;
    logic              exp_hold;
    int                miscompares = 0, samples_checked = 0, cycles = 0;

    iofs_top dut (.CLK_IN(clk), .RST_IN(rst), .REQ_VALID_IN(valid), .REQ_KIND_IN(kind),
        .REQ_CODE_IN(code), .REQ_READY_OUT(ready), .SENSE_RESP_IN(resp),
        .FUNC_CODE_OUT(code_out), .IN_FUNC_RDY_OUT(stb[0]), .IN_SENSE_RDY_OUT(stb[1]),
        .OUT_FUNC_RDY_OUT(stb[2]), .OUT_SENSE_RDY_OUT(stb[3]), .DONE_OUT(done),
        .RESULT_OUT(result), .REJECT_OUT(reject));
    // transfer group copy shares the request inputs
    iofs_top #(.TRANSFER_GROUP(1'b1)) dut_xfer (.CLK_IN(clk), .RST_IN(rst),
        .REQ_VALID_IN(valid), .REQ_KIND_IN(kind), .REQ_CODE_IN(code), .REQ_READY_OUT(),
        .SENSE_RESP_IN(resp), .FUNC_CODE_OUT(), .IN_FUNC_RDY_OUT(x_stb[0]),
        .IN_SENSE_RDY_OUT(x_stb[1]), .OUT_FUNC_RDY_OUT(x_stb[2]),
        .OUT_SENSE_RDY_OUT(x_stb[3]), .DONE_OUT(), .RESULT_OUT(), .REJECT_OUT(x_reject));
    iofs_equip equip (.clk_in(clk), .func_code_in(code_out), .strobe_in(stb),
        .salt_in(salt), .sense_resp_out(resp));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [CODE_W-1:0] exp, got);
        samples_checked++;
        if (exp !== got) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic test_done();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    // sense outcome after the condition flips mid-strobe
    function automatic logic sense_exp(input logic [CODE_W-1:0] c, input logic [10:0] s);
        return ^(c[11:1] ^ s) ^ c[0];
    endfunction : sense_exp

    // one request, watched cycle by cycle until done
    task automatic do_req(input logic [1:0] k, input logic [CODE_W-1:0] c,
                          input logic [10:0] s);
        int   n;
        int   w;
        logic rej_seen;
        logic exp_res;
        exp_res = k[0] ? sense_exp(c, s ^ 11'h001) : exp_hold;
        valid = 1'b1;
        kind = k;
        code = c;
        salt = s;
        for (w = 0; w < 2000 && ready !== 1'b1; w++) @(negedge clk);
        chk("ready", 12'h1, {11'h0, ready});
        @(negedge clk);
        valid = 1'b0;
        n = 0;
        rej_seen = 1'b0;
        for (w = 0; w < 800 && done !== 1'b1; w++) begin
            if (stb[k] === 1'b1) n++;
            if (w == 400) salt = s ^ 11'h001;
            rej_seen |= x_reject;
            chk("code", c, code_out);
            chk("other strobes", 12'h0, {8'h0, stb & ~(4'h1 << k)});
            chk("xfer input strobes", 12'h0, {10'h0, x_stb[1:0]});
            chk("ready busy", 12'h0, {11'h0, ready});
            chk("reject", 12'h0, {11'h0, reject});
            @(negedge clk);
        end
        chk("strobe length", 12'(STROBE_CYC), 12'(n));
        chk("done", 12'h1, {11'h0, done});
        chk("result", {11'h0, exp_res}, {11'h0, result});
        exp_hold = exp_res;
        chk("xfer reject", {11'h0, ~k[1]}, {11'h0, rej_seen});
    endtask : do_req

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            test_done();
        end
    end

    initial begin
        int r;
        int i;
        rst = 1'b1;
        valid = 1'b0;
        kind = 2'h0;
        code = 12'h000;
        salt = 11'h000;
        exp_hold = 1'b0;
        r = $urandom(32'hf8e9);
        repeat (16) @(negedge clk);
        chk("reset ready", 12'h1, {11'h0, ready});
        chk("reset code", 12'h0, code_out);
        chk("reset lines", 12'h0, {4'h0, stb, done, result, reject, x_reject});
        rst = 1'b0;
        // every kind with both inversion settings, then random traffic
        for (i = 0; i < 4; i++) begin
            do_req(2'(i), 12'hfff, 11'h7ff);
            do_req(2'(i), 12'h000, 11'h000);
        end
        // reset in mid sense strobe: lines drop at once, result clears
        @(negedge clk);
        valid = 1'b1;
        kind = 2'h3;
        code = 12'($urandom);
        @(negedge clk);
        valid = 1'b0;
        repeat (100) @(negedge clk);
        chk("strobe up", 12'h008, {8'h0, stb});
        rst = 1'b1;
        @(negedge clk);
        chk("reset strobes", 12'h0, {8'h0, stb});
        chk("reset result", 12'h0, {11'h0, result});
        rst = 1'b0;
        exp_hold = 1'b0;
        for (i = 0; i < 12; i++) do_req(2'($urandom), 12'($urandom), 11'($urandom));
        test_done();
    end
endmodule : tb_io_function_sense_signalling
